// >>> src/qpcd_pkg.sv
// shared constants and types of the quad pot command decoder
package qpcd_pkg;
  // register byte addresses on the AXI4-Lite port
  localparam logic [4:0] QPCD_CMD_ADDR = 5'h00;
  localparam logic [4:0] QPCD_STATUS_ADDR = 5'h04;
  localparam logic [4:0] QPCD_READBACK_ADDR = 5'h08;
  localparam logic [4:0] QPCD_CONFIG_ADDR = 5'h0C;
  localparam logic [4:0] QPCD_WIPER_ADDR = 5'h10;
  localparam logic [4:0] QPCD_PRELOAD_ADDR = 5'h14;
  // command word fields
  localparam int QPCD_OP_MSB = 15;
  localparam int QPCD_OP_LSB = 12;
  localparam int QPCD_CH_MSB = 11;
  localparam int QPCD_CH_LSB = 8;
  localparam int QPCD_DATA_MSB = 7;
  localparam int QPCD_DATA_LSB = 0;
  // opcodes
  localparam logic [3:0] QPCD_OP_NOP = 4'h0;
  localparam logic [3:0] QPCD_OP_WR_WIPER = 4'h1;
  localparam logic [3:0] QPCD_OP_WR_PRELOAD = 4'h2;
  localparam logic [3:0] QPCD_OP_READ = 4'h3;
  localparam logic [3:0] QPCD_OP_NV = 4'h7;
  localparam logic [3:0] QPCD_OP_TRANSFER = 4'h8;
  localparam logic [3:0] QPCD_OP_RESET = 4'hB;
  localparam logic [3:0] QPCD_OP_SHUTDOWN = 4'hC;
  // readback source select in data bits 1:0
  localparam logic [1:0] QPCD_RB_NV = 2'h1;
  localparam logic [1:0] QPCD_RB_PRELOAD = 2'h2;
  localparam logic [1:0] QPCD_RB_WIPER = 2'h3;
  // three-state pin codes
  localparam logic [1:0] QPCD_PIN_GND = 2'h0;
  localparam logic [1:0] QPCD_PIN_FLOAT = 2'h1;
  localparam logic [1:0] QPCD_PIN_SUPPLY = 2'h2;
  // values after reset
  localparam logic [7:0] QPCD_MIDSCALE = 8'h80;
  localparam logic [31:0] QPCD_WORDS_RESET = 32'h80808080;
  // reset clears the pin synchronisers, so the straps are only caught once
  // both flops hold real pin levels again, on the third edge after release
  localparam logic [1:0] QPCD_CAPTURE_AT = 2'h3;
  // AXI responses
  localparam logic [1:0] QPCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] QPCD_RESP_SLVERR = 2'h2;
  // timing at 25 MHz
  localparam int QPCD_CLK_HZ = 25000000;
  localparam int QPCD_STORE_MS = 15;
  localparam int QPCD_RELOAD_US = 30;
  localparam int QPCD_STORE_CYCLES = QPCD_STORE_MS * (QPCD_CLK_HZ / 1000);
  localparam int QPCD_RELOAD_CYCLES = QPCD_RELOAD_US * (QPCD_CLK_HZ / 1000000);
  localparam int QPCD_CNT_W = 19;
  // control states
  typedef enum logic [2:0] {
    QPCD_IDLE = 3'b001,
    QPCD_STORE = 3'b010,
    QPCD_RELOAD = 3'b100
  } qpcd_fsm_t;
endpackage : qpcd_pkg

// >>> src/qpcd_nvm.sv
// nonvolatile wiper store, four bytes, registered read words
`timescale 1ns/1ps
module qpcd_nvm
  import qpcd_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic we, // write enable pulse
  input wire logic [1:0] waddr, // channel written
  input wire logic [7:0] wdata, // value written
  output logic [31:0] words // all four stored bytes
);
  // reset stands in for the factory midscale contents
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      words <= QPCD_WORDS_RESET;
    end else if (we) begin
      words[waddr*8 +: 8] <= wdata;
    end
  end
endmodule : qpcd_nvm

// >>> src/qpcd_core.sv
// command decoder and register transfer logic of the quad pot
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module qpcd_core
  import qpcd_pkg::*;
#(
  parameter int STORE_CYCLES = QPCD_STORE_CYCLES // store busy time
)(
  input wire logic aclk, // 25 MHz clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [4:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [4:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [1:0] slave_address_select_pin_low, // three-state code
  input wire logic [1:0] slave_address_select_pin_high, // three-state code
  input wire logic single_pin_package, // strap: one address pin
  input wire logic variant_128, // strap: 128-position part
  input wire logic preload_transfer_strobe_pin_n, // load strobe, low
  input wire logic hw_reset_pin_n, // reset pin, low pulse
  output logic [6:0] slave_address, // chosen I2C slave address
  output logic [31:0] wiper_positions, // four wiper bytes
  output logic [3:0] shutdown, // per channel shutdown
  output logic busy // commands refused
);
  typedef struct packed {
    qpcd_fsm_t fsm;
    logic [QPCD_CNT_W-1:0] cnt;
    logic aw_held;
    logic [4:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] wipers;
    logic [31:0] preloads;
    logic [3:0] shut;
    logic [7:0] readback;
    logic [6:0] saddr;
    logic var128;
    logic [1:0] cap_cnt;
    logic [5:0] pins_s1;
    logic [5:0] pins_s2;
    logic [1:0] ctl_s1;
    logic [1:0] ctl_s2;
    logic rst_prev;
  } qpcd_regs_t;

  qpcd_regs_t r;
  qpcd_regs_t next_r;
  logic nv_we;
  logic [1:0] nv_waddr;
  logic [7:0] nv_wdata;
  logic [31:0] nv_words;

  // pin code to address: high pin picks the base, low pin the low bits
  function automatic logic [6:0] qpcd_addr(input logic [1:0] lo,
                                           input logic [1:0] hi);
    logic [6:0] a;
    a = 7'h28;
    if (hi == QPCD_PIN_SUPPLY) a = 7'h20;
    else if (hi == QPCD_PIN_GND) a = 7'h2C;
    if (lo == QPCD_PIN_GND) a[1:0] = 2'h3;
    else if (lo != QPCD_PIN_SUPPLY) a[1:0] = 2'h2;
    return a;
  endfunction : qpcd_addr

  // drop bit 0 on the 128-position part
  function automatic logic [7:0] qpcd_mask(input logic [7:0] v,
                                           input logic v128);
    return v128 ? {v[7:1], 1'b0} : v;
  endfunction : qpcd_mask

  qpcd_nvm u_nvm (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(nv_we),
    .waddr(nv_waddr),
    .wdata(nv_wdata),
    .words(nv_words)
  );

  // whole next state in one place
  always_comb begin
    logic [15:0] cmd;
    logic [3:0] op;
    logic [3:0] chf;
    logic [7:0] dat;
    logic [3:0] sel;
    logic single;
    logic do_cmd;
    logic refused;
    logic [31:0] rd;
    logic [1:0] rsp;
    cmd = r.w_data[15:0];
    op = cmd[QPCD_OP_MSB:QPCD_OP_LSB];
    chf = cmd[QPCD_CH_MSB:QPCD_CH_LSB];
    dat = cmd[QPCD_DATA_MSB:QPCD_DATA_LSB];
    sel = 4'h0;
    single = 1'b0;
    do_cmd = 1'b0;
    refused = 1'b0;
    rd = 32'h00000000;
    rsp = QPCD_RESP_OKAY;
    next_r = r;
    nv_we = 1'b0;
    nv_waddr = chf[1:0];
    nv_wdata = qpcd_mask(r.wipers[chf[1:0]*8 +: 8], r.var128);
    // two-flop synchronisers for every pin input
    next_r.pins_s1 = {single_pin_package, variant_128,
                      slave_address_select_pin_high,
                      slave_address_select_pin_low};
    next_r.pins_s2 = r.pins_s1;
    next_r.ctl_s1 = {hw_reset_pin_n, preload_transfer_strobe_pin_n};
    next_r.ctl_s2 = r.ctl_s1;
    next_r.rst_prev = r.ctl_s2[1];
    if (r.cap_cnt != QPCD_CAPTURE_AT) begin
      next_r.cap_cnt = r.cap_cnt + 2'h1;
      if (r.cap_cnt + 2'h1 == QPCD_CAPTURE_AT) begin
        next_r.var128 = r.pins_s2[4];
        if (r.pins_s2[5])
          next_r.saddr = qpcd_addr(r.pins_s2[1:0], QPCD_PIN_FLOAT);
        else
          next_r.saddr = qpcd_addr(r.pins_s2[1:0], r.pins_s2[3:2]);
      end
    end
    // strobe pin held low copies preloads
    if (!r.ctl_s2[0])
      next_r.wipers = r.preloads;
    // busy timers
    case (r.fsm)
      QPCD_IDLE: begin
      end
      QPCD_STORE: begin
        // hold busy for the store time
        next_r.cnt = r.cnt - 19'h00001;
        if (r.cnt == 19'h00001) next_r.fsm = QPCD_IDLE;
      end
      QPCD_RELOAD: begin
        next_r.cnt = r.cnt - 19'h00001;
        // wipers take the stored words when done
        if (r.cnt == 19'h00001) begin
          next_r.fsm = QPCD_IDLE;
          next_r.wipers = nv_words;
          next_r.preloads = nv_words;
        end
      end
      default: next_r.fsm = QPCD_IDLE;
    endcase
    // falling edge on reset pin starts a reload
    if (r.rst_prev && !r.ctl_s2[1]) begin
      next_r.fsm = QPCD_RELOAD;
      next_r.cnt = QPCD_CNT_W'(QPCD_RELOAD_CYCLES);
    end
    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      if (r.aw_addr == QPCD_CMD_ADDR) begin
        // a half-written command word would be garbage, so refuse it
        if (r.w_strb[1:0] != 2'h3 || r.fsm != QPCD_IDLE) refused = 1'b1;
        else do_cmd = 1'b1;
      end else if (r.aw_addr[1:0] != 2'h0 ||
                   r.aw_addr > QPCD_PRELOAD_ADDR) begin
        refused = 1'b1;
      end
      next_r.bresp = refused ? QPCD_RESP_SLVERR : QPCD_RESP_OKAY;
    end
    if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;
    if (chf[3:2] == 2'h0) begin
      sel = 4'h1 << chf[1:0];
      single = 1'b1;
    end else if (chf[3:2] == 2'h2) begin
      sel = 4'hF;
    end
    if (do_cmd) begin
      case (op)
        QPCD_OP_NOP: begin
        end
        QPCD_OP_WR_WIPER: begin
          for (int i = 0; i < 4; i++) begin
            if (sel[i] && single) begin
              next_r.wipers[i*8 +: 8] = qpcd_mask(dat, r.var128);
              next_r.preloads[i*8 +: 8] = qpcd_mask(dat, r.var128);
            end
          end
        end
        QPCD_OP_WR_PRELOAD: begin
          for (int i = 0; i < 4; i++)
            if (sel[i] && single) next_r.preloads[i*8 +: 8] = dat;
        end
        QPCD_OP_READ: begin
          if (chf[2] == 1'b0) begin
            case (dat[1:0])
              QPCD_RB_NV: next_r.readback =
                qpcd_mask(nv_words[chf[1:0]*8 +: 8], r.var128);
              QPCD_RB_WIPER: next_r.readback =
                qpcd_mask(r.wipers[chf[1:0]*8 +: 8], r.var128);
              QPCD_RB_PRELOAD: next_r.readback =
                r.preloads[chf[1:0]*8 +: 8];
              default: next_r.readback = r.readback;
            endcase
          end
        end
        QPCD_OP_NV: begin
          if (single && dat[0]) begin
            nv_we = 1'b1;
            next_r.fsm = QPCD_STORE;
            next_r.cnt = QPCD_CNT_W'(STORE_CYCLES);
          end else if (single) begin
            next_r.wipers[chf[1:0]*8 +: 8] = nv_words[chf[1:0]*8 +: 8];
            next_r.preloads[chf[1:0]*8 +: 8] = nv_words[chf[1:0]*8 +: 8];
          end
        end
        QPCD_OP_TRANSFER: begin
          // synchronous transfer, one or all channels
          for (int i = 0; i < 4; i++)
            if (sel[i])
              next_r.wipers[i*8 +: 8] =
                qpcd_mask(r.preloads[i*8 +: 8], r.var128);
        end
        QPCD_OP_RESET: begin
          // software reset reloads after the delay
          next_r.fsm = QPCD_RELOAD;
          next_r.cnt = QPCD_CNT_W'(QPCD_RELOAD_CYCLES);
        end
        QPCD_OP_SHUTDOWN: begin
          for (int i = 0; i < 4; i++)
            if (sel[i]) next_r.shut[i] = dat[0];
        end
        default: begin
        end
      endcase
    end
    // read channel: one cycle to answer
    if (s_axi_arvalid && s_axi_arready) begin
      case (s_axi_araddr)
        QPCD_CMD_ADDR: rd = 32'h00000000;
        QPCD_STATUS_ADDR: rd = {24'h000000, r.shut, 1'b0,
                                r.fsm == QPCD_RELOAD,
                                r.fsm == QPCD_STORE, r.fsm != QPCD_IDLE};
        QPCD_READBACK_ADDR: rd = {24'h000000, r.readback};
        QPCD_CONFIG_ADDR: rd = {24'h000000, r.var128, r.saddr};
        QPCD_WIPER_ADDR: rd = r.wipers;
        QPCD_PRELOAD_ADDR: rd = r.preloads;
        default: rsp = QPCD_RESP_SLVERR;
      endcase
      next_r.rvalid = 1'b1;
      next_r.rdata = rd;
      next_r.rresp = rsp;
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
  end

  // one register bank for the whole state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{fsm: QPCD_IDLE, wipers: QPCD_WORDS_RESET,
             preloads: QPCD_WORDS_RESET, saddr: 7'h28,
             pins_s1: 6'h00, pins_s2: 6'h00, ctl_s1: 2'h3, ctl_s2: 2'h3,
             rst_prev: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // handshakes from state, data straight from flops
  assign s_axi_awready = !r.aw_held;
  assign s_axi_wready = !r.w_held;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign slave_address = r.saddr;
  assign wiper_positions = r.wipers;
  assign shutdown = r.shut;
  assign busy = r.fsm != QPCD_IDLE;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic cmd_go;
  assign cmd_go = r.aw_held && r.w_held && !r.bvalid &&
                  r.aw_addr == QPCD_CMD_ADDR && r.w_strb[1:0] == 2'h3;

  store_busy_a: assert property (
    cmd_go && r.fsm == QPCD_IDLE && r.w_data[15:12] == QPCD_OP_NV &&
    r.w_data[11:10] == 2'h0 && r.w_data[0] |=> busy[*8])
    else $error("store did not hold busy");
  busy_refuse_a: assert property (
    cmd_go && busy |=> s_axi_bvalid && s_axi_bresp == QPCD_RESP_SLVERR)
    else $error("command taken while busy");
  nop_still_a: assert property (
    cmd_go && !busy && r.w_data[15:12] == QPCD_OP_NOP &&
    r.ctl_s2[0] && r.fsm == QPCD_IDLE |=> $stable(wiper_positions))
    else $error("no-op changed a wiper");
  wiper_write_a: assert property (
    cmd_go && !busy && r.w_data[15:10] == 6'h04 && !r.var128 |=>
    wiper_positions[$past(r.w_data[9:8])*8 +: 8] == $past(r.w_data[7:0]))
    else $error("wiper write lost");
  preload_follow_a: assert property (
    cmd_go && !busy && r.w_data[15:10] == 6'h04 |=>
    r.preloads[$past(r.w_data[9:8])*8 +: 8] ==
    r.wipers[$past(r.w_data[9:8])*8 +: 8])
    else $error("preload did not follow wiper");
  preload_only_a: assert property (
    cmd_go && !busy && r.w_data[15:10] == 6'h08 && r.ctl_s2[0] &&
    r.fsm == QPCD_IDLE |=> $stable(wiper_positions))
    else $error("preload write moved a wiper");
  bad_channel_a: assert property (
    cmd_go && !busy && r.w_data[11] == r.w_data[10] &&
    r.w_data[11] && r.ctl_s2[0] && r.fsm == QPCD_IDLE |=>
    $stable(wiper_positions) && $stable(r.preloads) && $stable(shutdown))
    else $error("invalid channel changed state");
  addr_held_a: assert property (
    r.cap_cnt == QPCD_CAPTURE_AT |=> $stable(slave_address))
    else $error("slave address moved after capture");
  mask_128_a: assert property (
    r.var128 && cmd_go && !busy && r.w_data[15:10] == 6'h04 |=>
    wiper_positions[$past(r.w_data[9:8])*8] == 1'b0)
    else $error("bit 0 kept on 128-position part");
endmodule : qpcd_core

// >>> sim/qpcd_host.sv
// AXI4-Lite master standing in for the controlling microcontroller
`timescale 1ns/1ps
module qpcd_host (
  input wire logic aclk, // system clock
  output logic [4:0] s_axi_awaddr, // write address
  output logic s_axi_awvalid, // write address valid
  input wire logic s_axi_awready, // write address ready
  output logic [31:0] s_axi_wdata, // write data
  output logic [3:0] s_axi_wstrb, // byte strobes
  output logic s_axi_wvalid, // write data valid
  input wire logic s_axi_wready, // write data ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // response valid
  output logic s_axi_bready, // response ready
  output logic [4:0] s_axi_araddr, // read address
  output logic s_axi_arvalid, // read address valid
  input wire logic s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // read data valid
  output logic s_axi_rready // read data ready
);
  // bus idle from time zero
  initial begin
    s_axi_awaddr = 5'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 5'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // one write; each channel dropped only once its own ready is seen
  task automatic write(input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 1000);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    if (n >= 1000) test_quad_pot_command_decoder.hung();
  endtask : write

  // one read; data taken at the edge that sees rvalid
  task automatic read(input logic [4:0] a, output logic [31:0] d,
                      output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 1000);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 1000) test_quad_pot_command_decoder.hung();
  endtask : read
endmodule : qpcd_host

// >>> sim/test_quad_pot_command_decoder.sv
// self-checking bench of the quad pot command decoder
`timescale 1ns/1ps
module test_quad_pot_command_decoder
  import qpcd_pkg::*;
;
  localparam int STORE_N = 20; // short store time keeps the run brief
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, wiper_positions, rdat;
  logic [3:0] s_axi_wstrb, shutdown;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, pin_lo = 2'h2, pin_hi = 2'h2;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, busy;
  logic one_pin = 1'b0, v128 = 1'b0, strobe_n = 1'b1, rst_pin_n = 1'b1;
  logic [6:0] slave_address;
  int bad_count = 0;
  int num_checks = 0;

  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end

  qpcd_core #(.STORE_CYCLES(STORE_N)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .slave_address_select_pin_low(pin_lo),
    .slave_address_select_pin_high(pin_hi), .single_pin_package(one_pin),
    .variant_128(v128), .preload_transfer_strobe_pin_n(strobe_n),
    .hw_reset_pin_n(rst_pin_n), .slave_address(slave_address),
    .wiper_positions(wiper_positions), .shutdown(shutdown), .busy(busy));

  qpcd_host i_host (
    .aclk(aclk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // a wait that ran out ends the run as a failure
  task automatic hung();
    bad_count++;
    results();
  endtask : hung

  // straps are set while reset is held, so they are settled at release
  task automatic do_reset(input logic [1:0] lo, input logic [1:0] hi,
                          input logic one, input logic v);
    @(posedge aclk);
    aresetn <= 1'b0;
    pin_lo <= lo;
    pin_hi <= hi;
    one_pin <= one;
    v128 <= v;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask : do_reset

  task automatic cmd(input logic [15:0] w, input logic [1:0] er);
    i_host.write(QPCD_CMD_ADDR, {16'h0000, w}, 4'hF, resp);
    chk(resp, er);
  endtask : cmd

  task automatic rb(input logic [15:0] w, input logic [7:0] e);
    cmd(w, QPCD_RESP_OKAY);
    i_host.read(QPCD_READBACK_ADDR, rdat, resp);
    chk(rdat[7:0], e);
  endtask : rb

  task automatic wait_idle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 2000) hung();
  endtask : wait_idle

  task automatic t_address();
    logic [6:0] two [9];
    two = '{7'h20, 7'h22, 7'h23, 7'h28, 7'h2A, 7'h2B, 7'h2C, 7'h2E, 7'h2F};
    for (int i = 0; i < 3; i++) begin
      do_reset(2'(2 - i), 2'h1, 1'b1, 1'b0);
      chk(slave_address, two[i + 3]);
    end
    for (int i = 0; i < 9; i++) begin
      do_reset(2'(2 - i % 3), 2'(2 - i / 3), 1'b0, 1'b0);
      chk(slave_address, two[i]);
    end
    // pins moved after capture must not move the address
    pin_lo <= 2'h2;
    pin_hi <= 2'h1;
    repeat (6) @(posedge aclk);
    chk(slave_address, 7'h2F);
    i_host.read(QPCD_CONFIG_ADDR, rdat, resp);
    chk(rdat[6:0], 7'h2F);
    i_host.read(5'h18, rdat, resp);
    chk(resp, QPCD_RESP_SLVERR);
  endtask : t_address

  task automatic t_transfer();
    do_reset(2'h2, 2'h2, 1'b0, 1'b0);
    cmd(16'h125B, QPCD_RESP_OKAY);
    chk(wiper_positions, 32'h805B8080);
    i_host.read(QPCD_PRELOAD_ADDR, rdat, resp);
    chk(rdat, 32'h805B8080);
    cmd(16'h213C, QPCD_RESP_OKAY);
    cmd(16'h0F77, QPCD_RESP_OKAY);
    cmd(16'h1499, QPCD_RESP_OKAY);
    cmd(16'h2C99, QPCD_RESP_OKAY);
    // a command word with its upper byte lane missing is refused
    i_host.write(QPCD_CMD_ADDR, 32'h00001099, 4'h1, resp);
    chk(resp, QPCD_RESP_SLVERR);
    chk(wiper_positions, 32'h805B8080);
    i_host.read(QPCD_PRELOAD_ADDR, rdat, resp);
    chk(rdat, 32'h805B3C80);
    cmd(16'h8B00, QPCD_RESP_OKAY);
    chk(wiper_positions, 32'h805B3C80);
    cmd(16'h2311, QPCD_RESP_OKAY);
    // strobe pin held low past its two-flop synchroniser
    strobe_n <= 1'b0;
    repeat (5) @(posedge aclk);
    strobe_n <= 1'b1;
    chk(wiper_positions, 32'h115B3C80);
    rb(16'h3303, 8'h11);
    rb(16'h3302, 8'h11);
    rb(16'h3301, 8'h80);
  endtask : t_transfer

  task automatic t_store();
    int n;
    do_reset(2'h2, 2'h2, 1'b0, 1'b0);
    cmd(16'h1042, QPCD_RESP_OKAY);
    cmd(16'h7001, QPCD_RESP_OKAY);
    chk(busy, 1'b1);
    cmd(16'h1199, QPCD_RESP_SLVERR);
    chk(wiper_positions, 32'h80808042);
    // still inside the store time: busy and storing flags both up
    i_host.read(QPCD_STATUS_ADDR, rdat, resp);
    chk(rdat[3:0], 4'h3);
    wait_idle(n);
    rb(16'h3001, 8'h42);
    cmd(16'h1010, QPCD_RESP_OKAY);
    cmd(16'h7000, QPCD_RESP_OKAY);
    chk(wiper_positions, 32'h80808042);
    cmd(16'h1177, QPCD_RESP_OKAY);
    cmd(16'hB000, QPCD_RESP_OKAY);
    wait_idle(n);
    chk({31'h0, n > 700 && n <= 750}, 32'h1);
    chk(wiper_positions, 32'h80808042);
    cmd(16'h1255, QPCD_RESP_OKAY);
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge aclk);
    rst_pin_n <= 1'b1;
    chk(busy, 1'b1);
    wait_idle(n);
    chk(wiper_positions, 32'h80808042);
  endtask : t_store

  // shutdown keeps wipers and still takes commands
  task automatic t_shutdown();
    cmd(16'hC801, QPCD_RESP_OKAY);
    chk(shutdown, 4'hF);
    cmd(16'h1366, QPCD_RESP_OKAY);
    chk(wiper_positions, 32'h66808042);
    cmd(16'hC100, QPCD_RESP_OKAY);
    chk(shutdown, 4'hD);
    i_host.read(QPCD_STATUS_ADDR, rdat, resp);
    chk(rdat[7:4], 4'hD);
  endtask : t_shutdown

  // 128-position part drops data bit 0
  task automatic t_narrow();
    do_reset(2'h2, 2'h2, 1'b0, 1'b1);
    cmd(16'h105B, QPCD_RESP_OKAY);
    chk(wiper_positions, 32'h8080805A);
    rb(16'h3003, 8'h5A);
    i_host.read(QPCD_CONFIG_ADDR, rdat, resp);
    chk(rdat[7], 1'b1);
  endtask : t_narrow

  // main sequence
  initial begin
    t_address();
    t_transfer();
    t_store();
    t_shutdown();
    t_narrow();
    results();
  end
endmodule : test_quad_pot_command_decoder
